/* File: logic/acs_integ_if.sv */
/*
 * Link between the sequencer and its up/down integrator.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface acs_integ_if;
	logic                                clear;
	logic                                step;
	logic                                bit_in;
	logic signed [acs_pkg::ACC_W-1:0]    acc;

	modport ctl (output clear, output step, output bit_in, input acc);
	modport core (input clear, input step, input bit_in, output acc);
endinterface

/* File: logic/acs_integrator.sv */
/*
 * Up/down integrator of the modulator bit stream.
 * Assumes step is a one-cycle pulse per converter tick and clear has priority.
 */
`timescale 1ns/1ps
module acs_integrator (
	// clock and reset
	input  wire logic   clk,
	input  wire logic   rst_n,
	// sequencer side
	acs_integ_if.core   io
);
	import acs_pkg::*;

	localparam logic signed [ACC_W-1:0] ACC_UP   = 18'sh00001;
	localparam logic signed [ACC_W-1:0] ACC_DOWN = -18'sh00001;

	acs_integ_type q;
	acs_integ_type d;

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		d = q;
		if (io.clear) begin
			d.acc = '0;
		end else if (io.step) begin
			d.acc = q.acc + (io.bit_in ? ACC_UP : ACC_DOWN);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign io.acc = q.acc;

endmodule

/* File: logic/acs_pkg.sv */
/*
 * Shared constants and types of the conversion slot sequencer.
 * Assumes a 10 MHz core clock and an analog front end that returns one
 * modulator bit per converter tick.
 */
package acs_pkg;

	// --------------------------------------------------------------
	// slots and register layout
	// --------------------------------------------------------------
	localparam int SLOT_COUNT    = 8;
	localparam int SLOT_IDX_W    = 3;
	localparam int CTRL_W        = 8;
	localparam int RESULT_W      = 16;
	localparam int MAG_W         = 15;
	localparam int SIGN_BIT      = 15;
	localparam int EN_BIT        = 7;
	localparam int RES_MSB       = 6;
	localparam int RES_LSB       = 4;
	localparam int REF_BIT       = 3;
	localparam int SRC_MSB       = 2;
	localparam int SRC_LSB       = 0;
	localparam int SRC_W         = 3;
	localparam int RES_W         = 3;
	localparam int RES_BASE_BITS = 8;
	localparam int RD_ADDR_W     = 4;
	localparam int RD_SEL_BIT    = 3;
	localparam logic [RES_W-1:0] RES_CODE_MAX = 3'h7;

	localparam logic [CTRL_W-1:0]   CTRL_RESET   = 8'h00;
	localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;

	// --------------------------------------------------------------
	// source select codes
	// --------------------------------------------------------------
	localparam logic [SRC_W-1:0] SRC_CURRENT  = 3'h0;
	localparam logic [SRC_W-1:0] SRC_DIE_TEMP = 3'h1;
	localparam logic [SRC_W-1:0] SRC_THERM    = 3'h2;
	localparam logic [SRC_W-1:0] SRC_PACK_V   = 3'h3;
	localparam logic [SRC_W-1:0] SRC_RESERVED = 3'h4;
	localparam logic [SRC_W-1:0] SRC_GP_INPUT = 3'h5;
	localparam logic [SRC_W-1:0] SRC_OFFSET   = 3'h6;
	localparam logic [SRC_W-1:0] SRC_UNUSED   = 3'h7;

	// --------------------------------------------------------------
	// slot roles
	// --------------------------------------------------------------
	localparam logic [SLOT_IDX_W-1:0] SLOT_CURRENT  = 3'h0;
	localparam logic [SLOT_IDX_W-1:0] SLOT_DIE_TEMP = 3'h1;
	localparam logic [SLOT_IDX_W-1:0] SLOT_THERM    = 3'h2;
	localparam logic [SLOT_IDX_W-1:0] SLOT_PACK_V   = 3'h3;
	localparam logic [SLOT_IDX_W-1:0] SLOT_RESERVED = 3'h4;
	localparam logic [SLOT_IDX_W-1:0] SLOT_GP_INPUT = 3'h5;
	localparam logic [SLOT_IDX_W-1:0] SLOT_OFFSET   = 3'h6;
	localparam logic [SLOT_IDX_W-1:0] SLOT_SPARE    = 3'h7;
	localparam logic [SLOT_IDX_W-1:0] SLOT_FIRST    = SLOT_CURRENT;
	localparam logic [SLOT_IDX_W-1:0] SLOT_LAST     = SLOT_SPARE;

	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int CLK_PERIOD_PS   = 100000;
	// one converter tick; the divided count rounds down to whole clocks
	localparam int TADC_UNIT_PS    = 30520000;
	localparam int TICK_CYCLES_DEF = TADC_UNIT_PS / CLK_PERIOD_PS;
	localparam int DIV_W           = 9;
	localparam int TICK_CNT_W      = 17;
	localparam int TICK_EXP_OFFS   = RES_BASE_BITS + 1;
	localparam int ACC_W           = 18;

	// --------------------------------------------------------------
	// types
	// --------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_SCAN  = 4'h2,
		ST_CONV  = 4'h4,
		ST_STORE = 4'h8
	} acs_state_type;

	typedef struct packed {
		acs_state_type                            st;
		logic [SLOT_IDX_W-1:0]                    slot;
		logic [CTRL_W-1:0]                        cur_ctrl;
		logic [DIV_W-1:0]                         div;
		logic [TICK_CNT_W-1:0]                    ticks;
		logic [SLOT_COUNT-1:0][CTRL_W-1:0]        ctrl;
		logic [SLOT_COUNT-1:0][RESULT_W-1:0]      result;
		logic [2:0]                               sync;
		logic                                     mod_bit;
		logic [SRC_W-1:0]                         mux;
		logic                                     ref_se;
		logic                                     gnd;
		logic                                     ntc_on;
		logic                                     conv;
		logic                                     done;
		logic [RESULT_W-1:0]                      rd_data;
	} acs_core_type;

	typedef struct packed {
		logic signed [ACC_W-1:0] acc;
	} acs_integ_type;

endpackage

/* File: logic/acs_sequencer.sv */
/*
 * Conversion slot sequencer: eight control slots, eight result words,
 * tick time base and result coding for a sigma-delta converter.
 * Assumes the two-wire host port sits outside and drives the register port;
 * the analog front end returns one modulator bit per tick, asynchronously.
 */
`timescale 1ns/1ps

// Summary of operation
// - while enabled, run conversion cycles of one to eight slots back to back
// - visit slots in index order, converting as each slot's fields say
// - enabled slot converts unless its source is 111; disabled or 111-source slot skipped at once to the next
// - each slot's outcome goes into its own 16-bit result word
// - 3-bit source field picks one of seven converter inputs
// - offset source grounds the converter input for the whole conversion
// - slot roles fixed: current, die temp, thermistor, pack, reserved, input, offset, spare
// - accumulation reads fixed result words, not programmable ones
// - 3-bit resolution field sets eight to fifteen magnitude bits
// - conversion with N bits lasts 30.52 us times two to N plus one
// - reference bit: differential 170mV or single-ended 340mV
// - results are sign in bit 15, magnitude in bits 14 to 0
// - fewer than fifteen bits: magnitude left-aligned, low bits zero
// - timing derives from the internal 131.072kHz time base, no crystal
// - slot byte: enable 7, resolution 6-4, reference 3, source 2-0
// - resolution is code plus eight bits
// - source 000 sense resistor, 011 pack voltage
module acs_sequencer #(
	parameter int unsigned TICK_CYCLES = acs_pkg::TICK_CYCLES_DEF
) (
	// clock and reset
	input  wire logic                               clk,
	input  wire logic                               rst_n,
	// control
	input  wire logic                               conv_enable,
	output logic                                    cycle_done,
	// register port
	input  wire logic                               ctrl_wr_en,
	input  wire logic [acs_pkg::SLOT_IDX_W-1:0]     ctrl_wr_slot,
	input  wire logic [acs_pkg::CTRL_W-1:0]         ctrl_wr_data,
	input  wire logic [acs_pkg::RD_ADDR_W-1:0]      reg_rd_addr,
	output logic [acs_pkg::RESULT_W-1:0]            reg_rd_data,
	// analog front end
	input  wire logic                               modulator_bit,
	output logic [acs_pkg::SRC_W-1:0]               mux_select,
	output logic                                    ref_single_ended,
	output logic                                    input_grounded,
	output logic                                    thermistor_source_on,
	output logic                                    converting,
	output logic [acs_pkg::SLOT_IDX_W-1:0]          active_slot,
	// fixed result words for accumulators and timers
	output logic [acs_pkg::RESULT_W-1:0]            pack_current_result,
	output logic [acs_pkg::RESULT_W-1:0]            die_temperature_result,
	output logic [acs_pkg::RESULT_W-1:0]            thermistor_result,
	output logic [acs_pkg::RESULT_W-1:0]            pack_voltage_result,
	output logic [acs_pkg::RESULT_W-1:0]            general_input_result,
	output logic [acs_pkg::RESULT_W-1:0]            offset_result,
	output logic [acs_pkg::RESULT_W-1:0]            spare_slot_result
);
	import acs_pkg::*;

	localparam logic [DIV_W-1:0]      DIV_LAST  = DIV_W'(TICK_CYCLES - 1);
	localparam logic [4:0]            EXP_OFFS  = 5'(TICK_EXP_OFFS);
	localparam logic [3:0]            RES_BASE  = 4'(RES_BASE_BITS);
	localparam acs_core_type          CORE_RST  = '{st: ST_IDLE, default: '0};

	acs_core_type q;
	acs_core_type d;

	acs_integ_if integ ();

	// --------------------------------------------------------------
	// slot decode and result coding
	// --------------------------------------------------------------
	logic [CTRL_W-1:0]         slot_ctrl;
	logic [SRC_W-1:0]          slot_src;
	logic                      slot_go;
	logic [RES_W-1:0]          cur_res;
	logic [SRC_W-1:0]          cur_src;
	logic [TICK_CNT_W-1:0]     total_ticks;
	logic                      tick;
	logic                      acc_neg;
	logic [TICK_CNT_W-1:0]     acc_mag;
	logic [MAG_W:0]            half_mag;
	logic [MAG_W:0]            mag_limit;
	logic [MAG_W:0]            mag_clamped;
	logic [RES_W-1:0]          pad_shift;
	logic [MAG_W-1:0]          mag_aligned;
	logic [MAG_W-1:0]          pad_mask;
	logic [RESULT_W-1:0]       result_word;

	always_comb begin
		slot_ctrl   = q.ctrl[q.slot];
		slot_src    = slot_ctrl[SRC_MSB:SRC_LSB];
		// unused source code behaves like a cleared enable
		slot_go     = slot_ctrl[EN_BIT] && (slot_src != SRC_UNUSED);
		cur_res     = q.cur_ctrl[RES_MSB:RES_LSB];
		cur_src     = q.cur_ctrl[SRC_MSB:SRC_LSB];
		// ticks per conversion: two to the (code plus nine)
		total_ticks = TICK_CNT_W'(1) << (5'(cur_res) + EXP_OFFS);
		// tick stands in for the converter clock of the trimmed time base
		tick        = (q.st == ST_CONV) && (q.div == DIV_LAST);
		acc_neg     = integ.acc < 0;
		acc_mag     = acc_neg ? TICK_CNT_W'(-integ.acc) : TICK_CNT_W'(integ.acc);
		half_mag    = acc_mag[TICK_CNT_W-1:1];
		// full-scale input would read one past the top code
		mag_limit   = ((MAG_W+1)'(1) << (4'(cur_res) + RES_BASE)) - (MAG_W+1)'(1);
		mag_clamped = (half_mag > mag_limit) ? mag_limit : half_mag;
		pad_shift   = RES_CODE_MAX - cur_res;
		mag_aligned = MAG_W'(mag_clamped << pad_shift);
		pad_mask    = MAG_W'(((MAG_W+1)'(1) << pad_shift) - (MAG_W+1)'(1));
		// no negative zero
		result_word = {acc_neg && (mag_aligned != '0), mag_aligned};
	end

	assign integ.clear  = (q.st == ST_SCAN) && conv_enable && slot_go;
	assign integ.step   = tick;
	assign integ.bit_in = q.mod_bit;

	acs_integrator u_integ (
		.clk   (clk),
		.rst_n (rst_n),
		.io    (integ)
	);

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		d      = q;
		d.done = 1'b0;

		// sync[0] is read only by sync[1]
		d.sync = {q.sync[1:0], modulator_bit};
		if (q.sync[1] == q.sync[2]) begin
			d.mod_bit = q.sync[2];
		end

		if (ctrl_wr_en) begin
			d.ctrl[ctrl_wr_slot] = ctrl_wr_data;
		end

		if (reg_rd_addr[RD_SEL_BIT]) begin
			d.rd_data = q.result[reg_rd_addr[SLOT_IDX_W-1:0]];
		end else begin
			d.rd_data = {{(RESULT_W-CTRL_W){1'b0}}, q.ctrl[reg_rd_addr[SLOT_IDX_W-1:0]]};
		end

		unique case (q.st)
			ST_IDLE: begin
				if (conv_enable) begin
					d.st   = ST_SCAN;
					d.slot = SLOT_FIRST;
				end
			end
			ST_SCAN: begin
				if (!conv_enable) begin
					d.st = ST_IDLE;
				end else if (slot_go) begin
					// fields frozen so host writes cannot disturb a running conversion
					d.cur_ctrl = slot_ctrl;
					d.mux      = slot_src;
					d.ref_se   = slot_ctrl[REF_BIT];
					d.gnd      = (slot_src == SRC_OFFSET);
					d.ntc_on   = (slot_src == SRC_THERM);
					d.conv     = 1'b1;
					d.div      = '0;
					d.ticks    = '0;
					d.st       = ST_CONV;
				end else begin
					d.done = (q.slot == SLOT_LAST);
					d.slot = SLOT_IDX_W'(q.slot + 3'h1);
				end
			end
			ST_CONV: begin
				if (!conv_enable) begin
					// aborted conversion leaves the old result in place
					d.st     = ST_IDLE;
					d.conv   = 1'b0;
					d.gnd    = 1'b0;
					d.ntc_on = 1'b0;
				end else if (tick) begin
					d.div   = '0;
					d.ticks = TICK_CNT_W'(q.ticks + 17'h00001);
					if (d.ticks == total_ticks) begin
						d.st = ST_STORE;
					end
				end else begin
					d.div = DIV_W'(q.div + 9'h001);
				end
			end
			ST_STORE: begin
				d.result[q.slot] = result_word;
				d.conv           = 1'b0;
				d.gnd            = 1'b0;
				d.ntc_on         = 1'b0;
				d.done           = (q.slot == SLOT_LAST);
				d.slot           = SLOT_IDX_W'(q.slot + 3'h1);
				d.st             = ST_SCAN;
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= CORE_RST;
		end else begin
			q <= d;
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign cycle_done           = q.done;
	assign reg_rd_data          = q.rd_data;
	assign mux_select           = q.mux;
	assign ref_single_ended     = q.ref_se;
	assign input_grounded       = q.gnd;
	assign thermistor_source_on = q.ntc_on;
	assign converting           = q.conv;
	assign active_slot          = q.slot;

	// accumulators see fixed words by slot role
	assign pack_current_result    = q.result[SLOT_CURRENT];
	assign die_temperature_result = q.result[SLOT_DIE_TEMP];
	assign thermistor_result      = q.result[SLOT_THERM];
	assign pack_voltage_result    = q.result[SLOT_PACK_V];
	assign general_input_result   = q.result[SLOT_GP_INPUT];
	assign offset_result          = q.result[SLOT_OFFSET];
	assign spare_slot_result      = q.result[SLOT_SPARE];

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence seq_slot_go;
		q.st == ST_SCAN && conv_enable && slot_go;
	endsequence

	sequence seq_conv_setup;
		q.st == ST_CONV && converting && q.ticks == '0;
	endsequence

	property p_start_conv;
		seq_slot_go |=> seq_conv_setup and (mux_select == $past(slot_src));
	endproperty

	a_cycle_wraps: assert property (q.done |-> q.st == ST_SCAN && q.slot == SLOT_FIRST)
		else $error("cycle end not followed by slot zero scan");

	a_slot_order: assert property (q.st == ST_STORE |=> q.slot == SLOT_IDX_W'($past(q.slot) + 3'h1))
		else $error("slot order broken after store");

	a_skip_fast: assert property (q.st == ST_SCAN && conv_enable && !slot_go
			|=> q.st == ST_SCAN && q.slot == SLOT_IDX_W'($past(q.slot) + 3'h1))
		else $error("disabled slot not skipped in one cycle");

	a_start_mux: assert property (p_start_conv)
		else $error("conversion start or source select wrong");

	a_offset_ground: assert property (q.st == ST_CONV |-> input_grounded == (cur_src == SRC_OFFSET))
		else $error("input ground does not match offset source");

	a_ref_mode: assert property (q.st == ST_CONV |-> ref_single_ended == q.cur_ctrl[REF_BIT])
		else $error("reference mode differs from slot field");

	a_conv_length: assert property (q.st == ST_STORE |-> q.ticks == total_ticks && $past(q.st) == ST_CONV)
		else $error("conversion length differs from resolution");

	a_pad_zero: assert property (q.st == ST_STORE |-> (result_word[MAG_W-1:0] & pad_mask) == '0)
		else $error("low magnitude bits not zero padded");

	a_store_write: assert property (q.st == ST_STORE |=> q.result[$past(q.slot)] == $past(result_word))
		else $error("result not written to its own slot");

	a_hold_result: assert property ($past(q.st) != ST_STORE |-> $stable(q.result))
		else $error("result changed without a completed conversion");

	sequence seq_abort;
		q.st == ST_CONV && !conv_enable;
	endsequence

	a_abort_idle: assert property (seq_abort |=> q.st == ST_IDLE && !converting)
		else $error("aborted conversion did not return to idle");

	a_ntc_source: assert property (q.st == ST_CONV
			|-> thermistor_source_on == (cur_src == SRC_THERM))
		else $error("thermistor source does not match slot source");

	a_idle_quiet: assert property (q.st == ST_IDLE |-> !converting && !input_grounded)
		else $error("front end controls active while idle");

endmodule

/* File: sim/acs_modulator_model.sv */
/*
 * Stand-in for the modulator of the converter front end.
 * Assumes one converter tick per clock; bits change on the falling edge.
 */
`timescale 1ns/1ps
module acs_modulator_model (
	// clock
	input  wire logic clk,
	// bench and sequencer controls
	input  wire logic drive_level,
	input  wire logic input_grounded,
	// to the sequencer
	output logic      modulator_bit
);
	logic [1:0] phase_q = 2'h0;

	initial modulator_bit = 1'b0;

	// grounded input gives a balanced stream, zero on average; each level
	// stands two clocks so the sequencer's input filter lets it through
	always @(negedge clk) begin
		phase_q <= phase_q + 2'h1;
		modulator_bit <= input_grounded ? phase_q[1] : drive_level;
	end
endmodule

/* File: sim/tb_acs_sequencer.sv */
/*
 * Bench of the conversion slot sequencer: register port, slot order,
 * conversion length, front-end controls, result coding and abort.
 * Assumes TICK_CYCLES of 1, so one converter tick per clock.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end

module tb_acs_sequencer;
	import acs_pkg::*;

	logic                  clk = 1'b0;
	logic                  rst_n = 1'b0;
	logic                  conv_enable = 1'b0;
	logic                  cycle_done;
	logic                  ctrl_wr_en = 1'b0;
	logic [SLOT_IDX_W-1:0] ctrl_wr_slot = 3'h0;
	logic [CTRL_W-1:0]     ctrl_wr_data = 8'h00;
	logic [RD_ADDR_W-1:0]  reg_rd_addr = 4'h0;
	logic [RESULT_W-1:0]   reg_rd_data;
	logic                  modulator_bit;
	logic                  drive_level = 1'b1;
	logic [SRC_W-1:0]      mux_select;
	logic                  ref_single_ended;
	logic                  input_grounded;
	logic                  thermistor_source_on;
	logic                  converting;
	logic [SLOT_IDX_W-1:0] active_slot;
	logic [RESULT_W-1:0]   fixed_res [8];
	logic [CTRL_W-1:0]     shadow [8];
	logic [RESULT_W-1:0]   e [8];
	logic [RESULT_W-1:0]   v;
	logic [SLOT_IDX_W-1:0] order [$];
	int                    lens [$];
	int                    bad_count = 0;
	int                    n_tests = 0;
	int                    cyc = 0;
	int                    run_len = 0;
	int                    k;
	// slots 1, 4 and 5 disabled, slot 7 enabled with the unused source
	logic [CTRL_W-1:0]     prog [8] = '{8'h80, 8'h02, 8'h82, 8'hAB,
	                                    8'h00, 8'h05, 8'h86, 8'h87};
	int                    exp_slot [4] = '{0, 2, 3, 6};

	acs_sequencer #(.TICK_CYCLES(1)) dut (
		.clk(clk), .rst_n(rst_n), .conv_enable(conv_enable), .cycle_done(cycle_done),
		.ctrl_wr_en(ctrl_wr_en), .ctrl_wr_slot(ctrl_wr_slot), .ctrl_wr_data(ctrl_wr_data),
		.reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .modulator_bit(modulator_bit),
		.mux_select(mux_select), .ref_single_ended(ref_single_ended),
		.input_grounded(input_grounded), .thermistor_source_on(thermistor_source_on),
		.converting(converting), .active_slot(active_slot),
		.pack_current_result(fixed_res[0]), .die_temperature_result(fixed_res[1]),
		.thermistor_result(fixed_res[2]), .pack_voltage_result(fixed_res[3]),
		.general_input_result(fixed_res[5]), .offset_result(fixed_res[6]),
		.spare_slot_result(fixed_res[7])
	);

	acs_modulator_model front_end (
		.clk(clk), .drive_level(drive_level), .input_grounded(input_grounded),
		.modulator_bit(modulator_bit)
	);

	initial forever #50 clk = ~clk;

	// --------------------------------------------------------------
	// watchdog and conversion monitor
	// --------------------------------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end

	always @(negedge clk) begin
		if (rst_n && converting) begin
			if (run_len == 0)
				order.push_back(active_slot);
			run_len++;
			`CHK("mux", shadow[active_slot][2:0], mux_select)
			`CHK("ref", shadow[active_slot][3], ref_single_ended)
			`CHK("gnd", shadow[active_slot][2:0] == SRC_OFFSET, input_grounded)
			`CHK("ntc", shadow[active_slot][2:0] == SRC_THERM, thermistor_source_on)
		end else if (run_len != 0) begin
			lens.push_back(run_len);
			run_len = 0;
		end
	end

	// --------------------------------------------------------------
	// access tasks
	// --------------------------------------------------------------
	task automatic wr(input int s, input logic [CTRL_W-1:0] d);
		@(negedge clk);
		ctrl_wr_en = 1'b1;
		ctrl_wr_slot = s[2:0];
		ctrl_wr_data = d;
		shadow[s] = d;
	endtask

	task automatic rd(input int a, output logic [RESULT_W-1:0] d);
		@(negedge clk);
		reg_rd_addr = a[3:0];
		@(negedge clk);
		d = reg_rd_data;
	endtask

	function automatic logic [RESULT_W-1:0] exp_res(logic [CTRL_W-1:0] c, logic lvl);
		int n;
		n = c[6:4] + 8;
		return {~lvl, 15'(((1 << n) - 1) << (15 - n))};
	endfunction

	// offset slot sign depends on stream phase, so only its size is judged
	task automatic check_results();
		for (int s = 0; s < 8; s++) begin
			rd(8 + s, v);
			if (s == 6) `CHK("offset mag", 5'h00, v[14:10])
			else `CHK("result word", e[s], v)
			if (s == 6) `CHK("offset fixed", 5'h00, fixed_res[6][14:10])
			else if (s != 4) `CHK("fixed word", e[s], fixed_res[s])
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// --------------------------------------------------------------
	// tests
	// --------------------------------------------------------------
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		for (int a = 0; a < 16; a++) begin
			rd(a, v);
			`CHK("reset value", 16'h0000, v)
		end
		$display("test reset values done");
		for (int s = 0; s < 8; s++)
			wr(s, 8'(s * 8'h25 + 8'h13));
		@(negedge clk);
		ctrl_wr_en = 1'b0;
		for (int s = 0; s < 8; s++) begin
			rd(s, v);
			`CHK("ctrl readback", {8'h00, shadow[s]}, v)
		end
		$display("test control bytes done");
		for (int s = 0; s < 8; s++)
			wr(s, prog[s]);
		@(negedge clk);
		ctrl_wr_en = 1'b0;
		conv_enable = 1'b1;
		k = 0;
		while (cycle_done !== 1'b1 && k < 8000) begin
			@(negedge clk);
			k++;
		end
		`CHK("cycle done", 1'b1, cycle_done)
		conv_enable = 1'b0;
		`CHK("conversions", 4, order.size())
		for (int i = 0; i < 4; i++) begin
			`CHK("slot order", exp_slot[i], order[i])
			// converting also stands through the one store cycle
			`CHK("conv length", (1 << (shadow[exp_slot[i]][6:4] + 9)) + 1, lens[i])
		end
		e = '{exp_res(prog[0], 1'b1), 16'h0000, exp_res(prog[2], 1'b1),
		      exp_res(prog[3], 1'b1), 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		check_results();
		$display("test full cycle done");
		// second cycle on negative input, cut short inside slot 3
		// only slots 0 and 2 store it; single-ended slot 3 never completes
		drive_level = 1'b0;
		repeat (10) @(negedge clk);
		order.delete();
		conv_enable = 1'b1;
		k = 0;
		while (order.size() < 3 && k < 3000) begin
			@(negedge clk);
			k++;
		end
		repeat (100) @(negedge clk);
		conv_enable = 1'b0;
		repeat (3) @(negedge clk);
		`CHK("stopped", 1'b0, converting)
		e[0] = exp_res(prog[0], 1'b0);
		e[2] = exp_res(prog[2], 1'b0);
		check_results();
		$display("test abort done");
		report_and_stop();
	end
endmodule
